// File: src/smcr_defs.svh
// Offsets, field positions, reset values and codes of the supply monitor registers
`ifndef SMCR_DEFS_SVH
`define SMCR_DEFS_SVH
`define SMCR_OFS_SYNC   5'h00
`define SMCR_OFS_BOD    5'h04
`define SMCR_OFS_VREG   5'h08
`define SMCR_OFS_CLKSR  5'h0C
`define SMCR_OFS_LCFG   5'h10
`define SMCR_OFS_LRATIO 5'h14
`define SMCR_SYNC_BIT   0
`define SMCR_RDY_BIT    0
`define SMCR_LMODE_BIT  1
`define SMCR_LCFG_RST   32'h0000_0000
`define SMCR_B_SFV      31
`define SMCR_B_FCD      16
`define SMCR_B_CTRL     9:8
`define SMCR_B_THRESHOLD_HYSTERESIS     6
`define SMCR_B_LEVEL    5:0
`define SMCR_V_SFV      31
`define SMCR_V_REGULATOR_PULLDOWN    30
`define SMCR_V_CVAL     25
`define SMCR_V_IVAL     24
`define SMCR_V_CMASK    23
`define SMCR_V_CSTAT    22
`define SMCR_V_CEN      21
`define SMCR_V_IMASK    20
`define SMCR_V_ISTAT    19
`define SMCR_V_IEN      18
`define SMCR_V_DEEP     17
`define SMCR_V_FCD      16
`define SMCR_V_TRIM_VALUE    11:8
`define SMCR_V_ON       7
`define SMCR_V_OK       6
`define SMCR_V_EN       5
`define SMCR_V_SEL      2:0
`define SMCR_SEL_1V8    3'h0
`define SMCR_VREG_RST   16'h1408
`define SMCR_CTRL_OFF   2'h0
`define SMCR_CTRL_RST   2'h1
`define SMCR_CTRL_IRQ   2'h2
`endif

// File: src/smcr_pkg.sv
// Types shared by the supply monitor register bank
package smcr_pkg;
   typedef struct packed {
      logic       store_final_lock;
      logic       fcd;
      logic [1:0] ctrl;
      logic       threshold_hysteresis;
      logic [5:0] level;
   } smcr_bod_t;
   typedef struct packed {
      logic       store_final_lock;
      logic       regulator_pulldown;
      logic       cMask;
      logic       cEn;
      logic       iMask;
      logic       iEn;
      logic       deep_mode_disable;
      logic       fcd;
      logic [3:0] trim;
      logic       en;
      logic [2:0] sel;
   } smcr_vreg_t;
   typedef struct packed {
      logic bodEvt;
      logic regGood;
      logic regOn;
      logic ioDetOn;
      logic coreDetOn;
      logic ioAbove;
      logic coreAbove;
   } smcr_ana_t;
   typedef enum logic [1:0] {
      SMCR_IDLE = 2'h0,
      SMCR_CAPT = 2'h1,
      SMCR_RDY  = 2'h3
   } smcr_sync_t;
endpackage

// File: src/smcr_top.sv
// Supply monitor control registers behind an Avalon-MM slave
//
// Local design decisions: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
`include "smcr_defs.svh"

// Function
// R01 - Software writes the sync request before reading closed-loop config or ratio.
// R02 - After sync request, snapshot config and ratio, then raise loop ready flag.
// R03 - Brownout lock makes register read-only; cleared by non-brownout reset, calibration.
// R04 - Brownout calibration-done clears on non-brownout reset, sets after fuse load.
// R05 - Brownout calibration reruns after any reset when done flag clear, else non-brownout.
// R06 - Brownout mode: off, reset-capable, interrupt-only, reserved; interrupt needs unmask.
// R07 - Software changes brownout level only while the detector is off.
// R08 - Regulator lock makes register read-only; only power-on reset clears it.
// R09 - Threshold, detector status, regulator on and good bits ignore writes.
// R10 - Core threshold bit reads one when core rail above its detector threshold.
// R11 - Io threshold bit reads one when regulator input above its threshold.
// R12 - Power-on mask bit at one masks matching detector output.
// R13 - Power-on enable bit turns matching detector off at zero, on at one.
// R14 - Detector status bit reads one while that detector is active.
// R15 - Deep mode in low-power sleep unless deep-mode-disable bit is one.
// R16 - Regulator calibration-done clears on power-on, sets after trim load.
// R17 - Software leaves the regulator trim field unchanged.
// R18 - Regulator-on flag reads one while regulator enabled.
// R19 - Output-good flag reads one only once enabled regulator reached threshold.
// R20 - Power-on reset forces regulator enable to one.
// R21 - Output select field picks regulator level; default means 1.8V.
// R22 - Loop mode bit one selects closed loop, zero open loop.
// R23 - While a lock bit is set every write to that register is ignored.
module smcr_top (
   input  wire logic                   clk_sys,
   input  wire logic                   sys_rst,
   input  wire logic                   por_rst,
   input  wire logic                   rstByBrownout,
   input  wire logic [4:0]             avs_address,
   input  wire logic                   avs_read,
   input  wire logic                   avs_write,
   input  wire logic [31:0]            avs_writedata,
   input  wire logic [3:0]             avs_byteenable,
   output logic [31:0]                 avs_readdata,
   output logic                        avs_waitrequest,
   input  wire smcr_pkg::smcr_bod_t    fuseBod,
   input  wire logic [3:0]             fuseTrim,
   input  wire smcr_pkg::smcr_ana_t    anaRaw,
   input  wire logic                   bodIrqUnmasked,
   input  wire logic                   sleepLowPower,
   input  wire logic [31:0]            loopCfgLive,
   input  wire logic [31:0]            loopRatioLive,
   output smcr_pkg::smcr_bod_t         bodCfg,
   output smcr_pkg::smcr_vreg_t        vregCfg,
   output logic [31:0]                 loopCfgOut,
   output logic                        bodRstReq,
   output logic                        bodIrqReq,
   output logic                        regDeep,
   output logic                        regOutputGood
);

   logic                  rstAny;
   logic                  postRst_q;
   logic                  waitReq_q;
   logic [31:0]           rdData_q;
   logic [31:0]           rdMux;
   logic                  reqNew;
   logic                  wrAcc;
   logic [31:0]           beMask;
   logic                  selSync;
   logic                  selBod;
   logic                  selVreg;
   logic                  selClkSr;
   logic                  selLCfg;
   logic                  selLRatio;
   smcr_pkg::smcr_ana_t   meta_q;
   smcr_pkg::smcr_ana_t   anaS_q;
   smcr_pkg::smcr_bod_t   bod_q;
   smcr_pkg::smcr_bod_t   bod_d;
   smcr_pkg::smcr_bod_t   bodNew;
   smcr_pkg::smcr_bod_t   bodCalVal;
   smcr_pkg::smcr_vreg_t  vreg_q;
   smcr_pkg::smcr_vreg_t  vreg_d;
   smcr_pkg::smcr_vreg_t  vregNew;
   smcr_pkg::smcr_vreg_t  vregCalVal;
   logic [31:0]           bodWord;
   logic [31:0]           vregWord;
   logic [31:0]           bodWrWord;
   logic [31:0]           vregWrWord;
   logic [31:0]           lcfgWrWord;
   logic                  bodCal;
   logic                  vregCal;
   logic                  bodWrOk;
   logic                  vregWrOk;
   logic [31:0]           loopCfg_q;
   logic [31:0]           loopCfg_d;
   logic [31:0]           cfgSnap_q;
   logic [31:0]           ratioSnap_q;
   logic [31:0]           lcfgRd;
   logic                  closedLoop;
   logic                  syncReq;
   smcr_pkg::smcr_sync_t  sync_q;
   logic                  loopReady_q;
   logic                  bodRstReq_q;
   logic                  bodIrq_q;
   logic                  regDeep_q;
   logic                  okFlag_q;
   logic                  bodArmed;

   // Power-on reset must also clear everything a system reset clears
   assign rstAny = sys_rst | por_rst;

   // Analogue levels arrive asynchronously; only anaS_q is read
   always_ff @(posedge clk_sys or posedge rstAny) begin
      if (rstAny) begin
         meta_q <= '0;
         anaS_q <= '0;
      end else begin
         meta_q <= anaRaw;
         anaS_q <= meta_q;
      end
   end

   // One cycle after any reset release, calibration and lock clearing act
   always_ff @(posedge clk_sys or posedge rstAny) begin
      if (rstAny) begin
         postRst_q <= 1'b1;
      end else begin
         postRst_q <= 1'b0;
      end
   end

   // Bus: an access answers one cycle after it is presented, two if presented in the first cycle after reset release
   assign reqNew = (avs_read | avs_write) & waitReq_q & ~postRst_q;
   assign wrAcc = avs_write & ~waitReq_q;
   assign beMask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                    {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

   assign selSync = (avs_address == `SMCR_OFS_SYNC);
   assign selBod = (avs_address == `SMCR_OFS_BOD);
   assign selVreg = (avs_address == `SMCR_OFS_VREG);
   assign selClkSr = (avs_address == `SMCR_OFS_CLKSR);
   assign selLCfg = (avs_address == `SMCR_OFS_LCFG);
   assign selLRatio = (avs_address == `SMCR_OFS_LRATIO);

   always_ff @(posedge clk_sys or posedge rstAny) begin
      if (rstAny) begin
         waitReq_q <= 1'b1;
         rdData_q <= 32'h0000_0000;
      end else begin
         waitReq_q <= ~reqNew;
         if (reqNew && avs_read) begin
            rdData_q <= rdMux;
         end
      end
   end

   assign avs_waitrequest = waitReq_q;
   assign avs_readdata = rdData_q;

   // Read side words
   assign bodWord = {bod_q.store_final_lock, 14'h0000, bod_q.fcd, 6'h00, bod_q.ctrl,
                     1'b0, bod_q.threshold_hysteresis, bod_q.level};
   // Live status bits are merged here, so writes cannot reach them
   assign vregWord = {vreg_q.store_final_lock, vreg_q.regulator_pulldown, 4'h0,  // R09
                      anaS_q.coreAbove,  // R10
                      anaS_q.ioAbove,  // R11
                      vreg_q.cMask,
                      anaS_q.coreDetOn,  // R14
                      vreg_q.cEn,
                      vreg_q.iMask,
                      anaS_q.ioDetOn,  // R14
                      vreg_q.iEn, vreg_q.deep_mode_disable, vreg_q.fcd, 4'h0, vreg_q.trim,
                      anaS_q.regOn,  // R18
                      okFlag_q,
                      vreg_q.en, 2'h0, vreg_q.sel};

   // Closed loop: the live fields read back only via the snapshot
   assign closedLoop = loopCfg_q[`SMCR_LMODE_BIT];  // R22
   assign lcfgRd = closedLoop ? {cfgSnap_q[31:8], loopCfg_q[7:0]} : loopCfg_q;

   // Unmapped offsets and the write-only sync word read as zero
   assign rdMux = selBod    ? bodWord :
                  selVreg   ? vregWord :
                  selClkSr  ? {31'h0000_0000, loopReady_q} :
                  selLCfg   ? lcfgRd :
                  selLRatio ? ratioSnap_q :
                  32'h0000_0000;

   assign bodWrWord = (bodWord & ~beMask) | (avs_writedata & beMask);
   assign vregWrWord = (vregWord & ~beMask) | (avs_writedata & beMask);
   assign lcfgWrWord = (loopCfg_q & ~beMask) | (avs_writedata & beMask);

   // Brownout register
   assign bodNew.store_final_lock = bodWrWord[`SMCR_B_SFV];
   assign bodNew.fcd = bodWrWord[`SMCR_B_FCD];
   assign bodNew.ctrl = bodWrWord[`SMCR_B_CTRL];
   assign bodNew.threshold_hysteresis = bodWrWord[`SMCR_B_THRESHOLD_HYSTERESIS];
   assign bodNew.level = bodWrWord[`SMCR_B_LEVEL];

   assign bodCalVal.store_final_lock = 1'b0;  // R03
   assign bodCalVal.fcd = 1'b1;  // R04
   assign bodCalVal.ctrl = fuseBod.ctrl;
   assign bodCalVal.threshold_hysteresis = fuseBod.threshold_hysteresis;
   assign bodCalVal.level = fuseBod.level;

   // A brownout reset keeps the calibration once it is done
   assign bodCal = postRst_q & (~bod_q.fcd | ~rstByBrownout);  // R05
   assign bodWrOk = wrAcc & selBod & ~bod_q.store_final_lock;  // R23
   assign bod_d = bodCal  ? bodCalVal :
                  bodWrOk ? bodNew :
                  bod_q;

   // Survives system resets; only power-on clears it outright
   always_ff @(posedge clk_sys or posedge por_rst) begin
      if (por_rst) begin
         bod_q <= '0;
      end else begin
         bod_q <= bod_d;  // R03
      end
   end

   // Regulator register; status bits are not stored here
   assign vregNew.store_final_lock = vregWrWord[`SMCR_V_SFV];
   assign vregNew.regulator_pulldown = vregWrWord[`SMCR_V_REGULATOR_PULLDOWN];
   assign vregNew.cMask = vregWrWord[`SMCR_V_CMASK];
   assign vregNew.cEn = vregWrWord[`SMCR_V_CEN];
   assign vregNew.iMask = vregWrWord[`SMCR_V_IMASK];
   assign vregNew.iEn = vregWrWord[`SMCR_V_IEN];
   assign vregNew.deep_mode_disable = vregWrWord[`SMCR_V_DEEP];
   assign vregNew.fcd = vregWrWord[`SMCR_V_FCD];
   // Trim stays writable; production values should be left alone
   assign vregNew.trim = vregWrWord[`SMCR_V_TRIM_VALUE];
   assign vregNew.en = vregWrWord[`SMCR_V_EN];
   assign vregNew.sel = vregWrWord[`SMCR_V_SEL];

   always_comb begin
      vregCalVal = vreg_q;
      vregCalVal.trim = fuseTrim;
      vregCalVal.fcd = 1'b1;  // R16
   end

   // Done flag drops at power-on or on a write of zero; while it is set, resets skip this
   assign vregCal = postRst_q & ~vreg_q.fcd;  // R16
   assign vregWrOk = wrAcc & selVreg & ~vreg_q.store_final_lock;  // R08 R23
   assign vreg_d = vregCal  ? vregCalVal :
                   vregWrOk ? vregNew :
                   vreg_q;

   always_ff @(posedge clk_sys or posedge por_rst) begin
      if (por_rst) begin
         vreg_q <= smcr_pkg::smcr_vreg_t'(`SMCR_VREG_RST);  // R20 R21
      end else begin
         vreg_q <= vreg_d;  // R12 R13
      end
   end

   // Loop configuration; coarse and fine are frozen in closed loop
   assign loopCfg_d = closedLoop ? {loopCfg_q[31:8], lcfgWrWord[7:0]} : lcfgWrWord;

   always_ff @(posedge clk_sys or posedge rstAny) begin
      if (rstAny) begin
         loopCfg_q <= `SMCR_LCFG_RST;
      end else if (wrAcc && selLCfg) begin
         loopCfg_q <= loopCfg_d;  // R22
      end
   end

   // Readback sync: request, one capture cycle, then ready
   assign syncReq = wrAcc & selSync & avs_byteenable[0]
                    & avs_writedata[`SMCR_SYNC_BIT];  // R01

   always_ff @(posedge clk_sys or posedge rstAny) begin
      if (rstAny) begin
         sync_q <= smcr_pkg::SMCR_IDLE;
         loopReady_q <= 1'b0;
         cfgSnap_q <= 32'h0000_0000;
         ratioSnap_q <= 32'h0000_0000;
      end else begin
         case (sync_q)
            smcr_pkg::SMCR_IDLE, smcr_pkg::SMCR_RDY: begin
               if (syncReq) begin
                  sync_q <= smcr_pkg::SMCR_CAPT;
                  loopReady_q <= 1'b0;
               end
            end
            smcr_pkg::SMCR_CAPT: begin
               // New request during capture simply restarts it
               cfgSnap_q <= loopCfgLive;  // R02
               ratioSnap_q <= loopRatioLive;  // R02
               sync_q <= syncReq ? smcr_pkg::SMCR_CAPT : smcr_pkg::SMCR_RDY;
               loopReady_q <= ~syncReq;  // R02
            end
            default: begin
               sync_q <= smcr_pkg::SMCR_IDLE;
            end
         endcase
      end
   end

   // Analogue controls and event outputs, all registered
   assign bodArmed = (bod_q.ctrl == `SMCR_CTRL_RST) | (bod_q.ctrl == `SMCR_CTRL_IRQ);

   always_ff @(posedge clk_sys or posedge rstAny) begin
      if (rstAny) begin
         bodRstReq_q <= 1'b0;
         bodIrq_q <= 1'b0;
         regDeep_q <= 1'b0;
         okFlag_q <= 1'b0;
      end else begin
         bodRstReq_q <= anaS_q.bodEvt & (bod_q.ctrl == `SMCR_CTRL_RST);  // R06
         bodIrq_q <= anaS_q.bodEvt & bodArmed & bodIrqUnmasked;  // R06
         regDeep_q <= sleepLowPower & ~vreg_q.deep_mode_disable;  // R15
         okFlag_q <= anaS_q.regGood & vreg_q.en;  // R19
      end
   end

   assign bodRstReq = bodRstReq_q;
   assign bodIrqReq = bodIrq_q;
   assign regDeep = regDeep_q;
   assign regOutputGood = okFlag_q;
   assign bodCfg = bod_q;
   assign vregCfg = vreg_q;
   assign loopCfgOut = loopCfg_q;

   default clocking smcrCb @(posedge clk_sys);
   endclocking
   default disable iff (rstAny);

   sequence SEQ_CAPTURE;
      !loopReady_q ##1 (loopReady_q && cfgSnap_q == $past(loopCfgLive));
   endsequence

   AST_SYNC_READY: assert property (  // R02
      (syncReq && sync_q != smcr_pkg::SMCR_CAPT) ##1 !syncReq |-> SEQ_CAPTURE)
      else $error("ready flag or snapshot wrong after sync request");

   AST_BOD_LOCK: assert property (  // R23
      (bod_q.store_final_lock && wrAcc && selBod && !postRst_q) |=> $stable(bod_q))
      else $error("locked brownout register changed on write");

   AST_VREG_LOCK: assert property (  // R08
      (vreg_q.store_final_lock && !postRst_q) |=> vreg_q.store_final_lock && $stable(vreg_q))
      else $error("locked regulator register changed");

   AST_BOD_CAL: assert property (  // R04
      (postRst_q && !rstByBrownout) |=> bod_q.fcd && !bod_q.store_final_lock
      && bod_q.level == $past(fuseBod.level))
      else $error("brownout calibration not applied after reset");

   AST_BOD_RST: assert property (  // R06
      bodRstReq_q |-> $past(bod_q.ctrl) == `SMCR_CTRL_RST && $past(anaS_q.bodEvt))
      else $error("brownout reset request in wrong mode");

   AST_BOD_IRQ: assert property (  // R06
      bodIrq_q |-> $past(bodIrqUnmasked) && $past(bod_q.ctrl) != `SMCR_CTRL_OFF)
      else $error("brownout interrupt while masked or disabled");

   AST_DEEP: assert property (  // R15
      regDeep_q |-> $past(sleepLowPower) && !$past(vreg_q.deep_mode_disable))
      else $error("deep mode entered while disabled");

   AST_REGULATOR_OUTPUT_GOOD: assert property (  // R19
      okFlag_q |-> $past(vreg_q.en) && $past(anaS_q.regGood))
      else $error("output good while regulator disabled");

   AST_WAIT: assert property (  // local Avalon-MM design decision
      reqNew |=> !waitReq_q ##1 waitReq_q)
      else $error("bus answer not one cycle wide");

   AST_VREG_CAL: assert property (  // R16
      (postRst_q && !vreg_q.fcd) |=> vreg_q.fcd && vreg_q.trim == $past(fuseTrim))
      else $error("regulator trim not loaded");

endmodule

// File: test/smcr_top_tb.sv
// Self-checking bench for the supply monitor register bank
`timescale 1ns/1ps
`include "smcr_defs.svh"

module smcr_top_tb;
   typedef struct packed {
      logic [6:0]  ana;
      logic [4:0]  addr;
      logic        wr;
      logic [31:0] wdata;
      logic [31:0] exp;
   } smcr_row_t;

   logic                 clk_sys;
   logic                 sys_rst;
   logic                 por_rst;
   logic                 rstByBrownout;
   logic [4:0]           avs_address;
   logic                 avs_read;
   logic                 avs_write;
   logic [31:0]          avs_writedata;
   logic [3:0]           avs_byteenable;
   logic [31:0]          avs_readdata;
   logic                 avs_waitrequest;
   smcr_pkg::smcr_bod_t  fuseBod;
   logic [3:0]           fuseTrim;
   smcr_pkg::smcr_ana_t  anaRaw;
   logic                 bodIrqUnmasked;
   logic                 sleepLowPower;
   logic [31:0]          loopCfgLive;
   logic [31:0]          loopRatioLive;
   smcr_pkg::smcr_bod_t  bodCfg;
   smcr_pkg::smcr_vreg_t vregCfg;
   logic [31:0]          loopCfgOut;
   logic                 bodRstReq;
   logic                 bodIrqReq;
   logic                 regDeep;
   logic                 regOutputGood;
   smcr_row_t            rows [8];
   int                   errors;
   int                   n_tests;

   smcr_top dut (
      .clk_sys         (clk_sys),
      .sys_rst         (sys_rst),
      .por_rst         (por_rst),
      .rstByBrownout   (rstByBrownout),
      .avs_address     (avs_address),
      .avs_read        (avs_read),
      .avs_write       (avs_write),
      .avs_writedata   (avs_writedata),
      .avs_byteenable  (avs_byteenable),
      .avs_readdata    (avs_readdata),
      .avs_waitrequest (avs_waitrequest),
      .fuseBod         (fuseBod),
      .fuseTrim        (fuseTrim),
      .anaRaw          (anaRaw),
      .bodIrqUnmasked  (bodIrqUnmasked),
      .sleepLowPower   (sleepLowPower),
      .loopCfgLive     (loopCfgLive),
      .loopRatioLive   (loopRatioLive),
      .bodCfg          (bodCfg),
      .vregCfg         (vregCfg),
      .loopCfgOut      (loopCfgOut),
      .bodRstReq       (bodRstReq),
      .bodIrqReq       (bodIrqReq),
      .regDeep         (regDeep),
      .regOutputGood   (regOutputGood)
   );

   always #50 clk_sys = ~clk_sys;

   task end_sim;
      $display("errors %0d comparisons %0d", errors, n_tests);
      if (errors == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task chk32(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task chk1(input logic got, input logic exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Request held until waitrequest is seen low at a rising edge
   task bus(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      avs_address   <= a;
      avs_writedata <= d;
      avs_read      <= ~w;
      avs_write     <= w;
      n = 0;
      @(posedge clk_sys);
      while (avs_waitrequest !== 1'b0 && n < 20) begin
         @(posedge clk_sys);
         n++;
      end
      if (n >= 20) begin
         errors++;
         end_sim;
      end
      q = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
      // One idle edge so the next request never lands in the release step
      @(posedge clk_sys);
   endtask

   task wr(input logic [4:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask

   task rdchk(input logic [4:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 32'h0000_0000, q);
      chk32(q, exp);
   endtask

   // Two synchroniser stages plus the output register, with margin
   task settle;
      repeat (4) @(posedge clk_sys);
   endtask

   task do_rst(input logic por, input logic bo);
      sys_rst       <= 1'b1;
      por_rst       <= por;
      rstByBrownout <= bo;
      repeat (16) @(posedge clk_sys);
      sys_rst <= 1'b0;
      por_rst <= 1'b0;
      repeat (2) @(posedge clk_sys);
      rstByBrownout <= 1'b0;
      @(posedge clk_sys);
   endtask

   initial begin
      int          i;
      int          c;
      int          m;
      int          n;
      logic [31:0] q;
      clk_sys        = 1'b0;
      sys_rst        = 1'b1;
      por_rst        = 1'b1;
      rstByBrownout  = 1'b0;
      avs_address    = 5'h00;
      avs_read       = 1'b0;
      avs_write      = 1'b0;
      avs_writedata  = 32'h0000_0000;
      avs_byteenable = 4'hF;
      fuseBod        = 11'h26A;
      fuseTrim       = 4'hA;
      anaRaw         = 7'h35;
      bodIrqUnmasked = 1'b0;
      sleepLowPower  = 1'b1;
      loopCfgLive    = 32'h0000_0000;
      loopRatioLive  = 32'h0000_0000;
      errors         = 0;
      n_tests        = 0;
      // Analogue levels, address, write flag, write data, expected read
      rows = '{'{7'h35, `SMCR_OFS_VREG, 1'b0, 32'h0000_0000, 32'h0265_0AE0},
               '{7'h3A, `SMCR_OFS_VREG, 1'b0, 32'h0000_0000, 32'h012D_0AE0},
               '{7'h35, `SMCR_OFS_VREG, 1'b1, 32'h019F_0A22, 32'h02D7_0AE2},
               '{7'h35, `SMCR_OFS_BOD,  1'b1, 32'h0001_0255, 32'h0001_0255},
               '{7'h35, `SMCR_OFS_SYNC, 1'b0, 32'h0000_0000, 32'h0000_0000},
               '{7'h35, 5'h18,          1'b0, 32'h0000_0000, 32'h0000_0000},
               '{7'h35, 5'h1C,          1'b1, 32'hFFFF_FFFF, 32'h0000_0000},
               '{7'h35, `SMCR_OFS_LCFG, 1'b1, 32'hAB01_2D0D, 32'hAB01_2D0D}};
      @(posedge clk_sys);
      do_rst(1'b1, 1'b0);
      // Output-good trails release by two synchroniser stages and its register
      settle;
      chk1(regDeep, 1'b1);
      chk1(regOutputGood, 1'b1);
      rdchk(`SMCR_OFS_BOD, 32'h0001_006A);
      for (i = 0; i < 8; i++) begin
         anaRaw <= rows[i].ana;
         settle;
         if (rows[i].wr) begin
            wr(rows[i].addr, rows[i].wdata);
         end
         rdchk(rows[i].addr, rows[i].exp);
      end
      chk32(32'(vregCfg), 32'h0000_2FAA);
      chk32(32'(bodCfg), 32'h0000_0355);
      chk32(loopCfgOut, 32'hAB01_2D0D);
      chk1(regDeep, 1'b0);
      anaRaw.bodEvt <= 1'b1;
      for (c = 0; c < 4; c++) begin
         for (m = 0; m < 2; m++) begin
            wr(`SMCR_OFS_BOD, {15'h0000, 1'b1, 6'h00, c[1:0], 8'h15});
            bodIrqUnmasked <= m[0];
            settle;
            chk1(bodRstReq, c == 1);
            chk1(bodIrqReq, (c == 1 || c == 2) && m == 1);
         end
      end
      anaRaw <= 7'h15;
      settle;
      chk1(regOutputGood, 1'b0);
      anaRaw <= 7'h35;
      loopCfgLive   <= 32'h5501_7700;
      loopRatioLive <= 32'h1234_0011;
      wr(`SMCR_OFS_LCFG, 32'h0000_0003);
      wr(`SMCR_OFS_SYNC, 32'h0000_0001);
      n = 0;
      q = 32'h0000_0000;
      while (q[0] !== 1'b1 && n < 10) begin
         bus(1'b0, `SMCR_OFS_CLKSR, 32'h0000_0000, q);
         n++;
      end
      chk1(q[0], 1'b1);
      // Ready never seen: the poll ran out, stop here
      if (q[0] !== 1'b1) begin
         end_sim;
      end
      // Live values move on; the snapshot must not
      loopCfgLive   <= 32'h0000_0000;
      loopRatioLive <= 32'h0000_0000;
      rdchk(`SMCR_OFS_LCFG, 32'h5501_7703);
      rdchk(`SMCR_OFS_LRATIO, 32'h1234_0011);
      wr(`SMCR_OFS_LCFG, 32'hFF00_0003);
      rdchk(`SMCR_OFS_LCFG, 32'h5501_7703);
      wr(`SMCR_OFS_BOD, 32'h8001_0255);
      wr(`SMCR_OFS_BOD, 32'h0001_0100);
      rdchk(`SMCR_OFS_BOD, 32'h8001_0255);
      do_rst(1'b0, 1'b1);
      rdchk(`SMCR_OFS_BOD, 32'h8001_0255);
      do_rst(1'b0, 1'b0);
      rdchk(`SMCR_OFS_BOD, 32'h0001_006A);
      wr(`SMCR_OFS_VREG, 32'h819F_0A22);
      wr(`SMCR_OFS_VREG, 32'h0000_0000);
      rdchk(`SMCR_OFS_VREG, 32'h82D7_0AE2);
      do_rst(1'b0, 1'b0);
      rdchk(`SMCR_OFS_VREG, 32'h82D7_0AE2);
      do_rst(1'b1, 1'b0);
      rdchk(`SMCR_OFS_VREG, 32'h0265_0AE0);
      rdchk(`SMCR_OFS_BOD, 32'h0001_006A);
      end_sim;
   end
endmodule
